//--- dct_bank_timer.sv
/*
 * dct_bank_timer: down-counter that holds one bank busy for a loaded
 * number of cycles and pulses done when it runs out.
 * Assumes load is a one-cycle pulse from logic on the same clock.
 */
`default_nettype none
module dct_bank_timer
   import dct_pkg::*;
#(
   parameter int W = 8
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   output logic busy,
   output logic done
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic done_r;
   logic done_nxt;

   // ------------------------------------------------------------------
   // count down; a reload restarts the wait
   // ------------------------------------------------------------------
   always_comb
   begin
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      if (load)
      begin
         cnt_nxt = load_val;
      end
      else if (cnt_r != '0)
      begin
         cnt_nxt = cnt_r - 1'b1;
         done_nxt = (cnt_r == W'(1));
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt_r <= '0;
         done_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign busy = (cnt_r != '0);
   assign done = done_r;
endmodule // dct_bank_timer
`default_nettype wire

//--- dct_checker.sv
/* dct_checker: timing assertions on the pin-to-output paths of dct_top.
   Assumes it is bound into dct_top and sees only that module's ports. */
`default_nettype none
module dct_checker
   import dct_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire dct_pins_t pins,
   input wire logic term_en,
   input wire logic read_allowed,
   input wire logic [NUM_BANKS-1:0] bank_open
);
   // ------------------------------------------------------------
   // shadow of mode fields, exit kind and event counters
   // ------------------------------------------------------------
   logic cke_q_r, cke_q_nxt, slow_r, slow_nxt, sel;
   logic [1:0] kind_r, kind_nxt, apb_r, apb_nxt;
   logic [2:0] wr_r, wr_nxt, al_r, al_nxt, c3;
   logic [8:0] xcnt_r, xcnt_nxt, acnt_r, acnt_nxt, gap;
   // decode commands; counters saturate so old events never alias
   always_comb
   begin
      sel = !pins.cs_n && pins.cke && cke_q_r;
      c3 = {pins.ras_n, pins.cas_n, pins.we_n};
      cke_q_nxt = pins.cke;
      wr_nxt = wr_r;
      al_nxt = al_r;
      slow_nxt = slow_r;
      kind_nxt = kind_r;
      apb_nxt = apb_r;
      xcnt_nxt = xcnt_r + {8'h0, xcnt_r != 9'h1FF};
      acnt_nxt = acnt_r + {8'h0, acnt_r != 9'h1FF};
      if (sel && c3 == 3'h0 && pins.ba == 2'h0)
      begin
         wr_nxt = pins.addr[11:9];
         slow_nxt = pins.addr[MR_SLOW_EXIT_BIT];
      end
      if (sel && c3 == 3'h0 && pins.ba == 2'h1)
         al_nxt = pins.addr[5:3];
      if (sel && c3 == 3'h4 && pins.addr[PRECHARGE_ALL_BIT])
      begin
         apb_nxt = pins.ba;
         acnt_nxt = 9'h0;
      end
      if (cke_q_r && !pins.cke)
         kind_nxt = (!pins.cs_n && c3 == 3'h1) ? 2'h2 : {1'h0, |bank_open};
      if (!cke_q_r && pins.cke)
         xcnt_nxt = 9'h0;
      gap = 9'(PRECHARGE_PD_EXIT_CYC);
      if (kind_r == 2'h2)
         gap = 9'(SELFREFRESH_EXIT_READ_CYC);
      else if (kind_r == 2'h1 && slow_r)
         gap = (al_r < 3'h5) ? 9'h6 - {6'h0, al_r} : 9'h1;
   end
   // register the shadow state
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cke_q_r <= 1'h1;
         slow_r <= 1'h0;
         kind_r <= 2'h0;
         apb_r <= 2'h0;
         wr_r <= 3'h0;
         al_r <= 3'h0;
         xcnt_r <= 9'h1FF;
         acnt_r <= 9'h1FF;
      end
      else
      begin
         cke_q_r <= cke_q_nxt;
         slow_r <= slow_nxt;
         kind_r <= kind_nxt;
         apb_r <= apb_nxt;
         wr_r <= wr_nxt;
         al_r <= al_nxt;
         xcnt_r <= xcnt_nxt;
         acnt_r <= acnt_nxt;
      end
   end
   // ------------------------------------------------------------
   // properties; sync delay leaves a little slack on each figure
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   sequence s_odt_rise;
      (!pins.odt && pins.cke)[*6] ##1 (pins.odt && pins.cke);
   endsequence
   sequence s_odt_fall;
      (pins.odt && pins.cke)[*6] ##1 (!pins.odt && pins.cke);
   endsequence
   AST_TERM_ON: assert property (s_odt_rise |-> (!term_en)[*4] ##[1:2] term_en)
      else $error("termination turned on at the wrong cycle");
   AST_TERM_OFF: assert property (s_odt_fall |-> term_en[*4] ##[1:2] !term_en)
      else $error("termination turned off at the wrong cycle");
   AST_READ_GATE: assert property ($rose(read_allowed) |-> xcnt_r > gap && xcnt_r <= gap + 9'h4)
      else $error("read allowed at the wrong exit gap");
   AST_READ_DROP: assert property ($rose(pins.cke) |-> ##[1:4] !read_allowed)
      else $error("read not blocked after exit");
   AST_AP_CLOSE: assert property ($fell(bank_open[apb_r]) && acnt_r < 9'h28
      |-> acnt_r > {6'h0, wr_r} + 9'h2 && acnt_r <= {6'h0, wr_r} + 9'h6)
      else $error("auto precharge closed bank at the wrong time");
   AST_TERM_IDLE: assert property ((!pins.odt)[*8] |-> !term_en)
      else $error("termination on without a request");
endmodule // dct_checker
bind dct_top dct_checker dct_checker_inst (.clk(clk), .srst(srst), .pins(pins),
   .term_en(term_en), .read_allowed(read_allowed), .bank_open(bank_open));
`default_nettype wire

//--- dct_ctrl_model.sv
/* dct_ctrl_model: behavioural memory controller on the pins of dct_top.
   Assumes one 25 ns clock; pins change just after a rising edge. */
`default_nettype none
module dct_ctrl_model
   import dct_pkg::*;
(
   input wire logic clk,
   output var dct_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // spacing in whole cycles, nanosecond minimums rounded up
   // ------------------------------------------------------------
   localparam int MODE_GAP = 2;
   localparam int ACT_GAP = 2; // two cycles cover 15 ns and 7.5 ns
   localparam int COL_GAP = 2;
   localparam int PRE_GAP = (105 + 24) / 25; // also covers refresh
   int slack = 0;
   initial pins = '{cke: 1'h1, cs_n: 1'h1, ras_n: 1'h1, cas_n: 1'h1, we_n: 1'h1, default: '0};
   // one command cycle, then deselects for the gap plus any slowness
   task issue(input logic [2:0] c, input logic [1:0] b, input logic [13:0] a, input int gap);
      @(posedge clk);
      pins.cs_n <= 1'h0;
      {pins.ras_n, pins.cas_n, pins.we_n} <= c;
      pins.ba <= b;
      pins.addr <= a;
      @(posedge clk);
      pins.cs_n <= 1'h1;
      {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h7;
      pins.addr <= ~a; // stale address must never look valid
      repeat (gap + slack) @(posedge clk);
   endtask
   task mode(input logic [1:0] b, input logic [13:0] a);
      issue(3'h0, b, a, MODE_GAP);
   endtask
   task act(input logic [1:0] b);
      issue(3'h3, b, 14'h0, ACT_GAP);
   endtask
   // no strobe pins here: the data burst is not driven
   task wr_ap(input logic [1:0] b);
      issue(3'h4, b, 14'h0400, COL_GAP);
   endtask
   task refresh;
      issue(3'h1, 2'h0, 14'h0, PRE_GAP);
   endtask
   task pre_all;
      issue(3'h2, 2'h0, 14'h0400, PRE_GAP);
   endtask
   task set_odt(input logic v);
      @(posedge clk);
      pins.odt <= v;
   endtask
   // hold level and termination first, then switch clock enable
   task power(input logic lvl, input logic sref);
      repeat (3) @(posedge clk);
      pins.cke <= lvl;
      if (sref)
      begin
         pins.cs_n <= 1'h0;
         {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h1;
      end
      @(posedge clk);
      pins.cs_n <= 1'h1;
      {pins.ras_n, pins.cas_n, pins.we_n} <= 3'h7;
   endtask
endmodule // dct_ctrl_model
`default_nettype wire

//--- dct_pkg.sv
/*
 * dct_pkg: shared constants, types and register map for the memory-side
 * command timing block.
 * Assumes a single 40 MHz clock and an AHB-Lite register bus of 32 bits.
 */
`default_nettype none
package dct_pkg;
   // ------------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 25000;
   localparam int PRECHARGE_PERIOD_PS = 15000;
   localparam int PRECHARGE_PERIOD_CYC = (PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TERM_ON_DELAY_CYC = 2;
   localparam int ACTIVE_PD_FAST_EXIT_CYC = 2;
   localparam int ACTIVE_PD_SLOW_EXIT_BASE_CYC = 6;
   localparam int PRECHARGE_PD_EXIT_CYC = 2;
   localparam int SELFREFRESH_EXIT_READ_CYC = 200;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] REG_CTRL_OFS = 8'h00;
   localparam logic [7:0] REG_STATUS_OFS = 8'h04;
   localparam logic [7:0] REG_MODE_OFS = 8'h08;
   localparam int CTRL_TERM_EN_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   // mode register fields as carried on the address pins
   localparam int MR_WR_LSB = 9;
   localparam int MR_SLOW_EXIT_BIT = 12;
   localparam int EMR_AL_LSB = 3;
   localparam int PRECHARGE_ALL_BIT = 10;
   localparam int NUM_BANKS = 4;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic cke;
      logic odt;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [1:0] ba;
      logic [13:0] addr;
   } dct_pins_t;

   typedef enum logic [4:0] {
      PS_ACTIVE = 5'b00001,
      PS_PD_PRE = 5'b00010,
      PS_PD_ACT = 5'b00100,
      PS_SELFREF = 5'b01000,
      PS_EXIT = 5'b10000
   } dct_pstate_t;
endpackage : dct_pkg
`default_nettype wire

//--- dct_tb.sv
/* testbench: drives dct_top through the controller model and an
   AHB-Lite master. Assumes the checker is bound in by its own file. */
`default_nettype none
module testbench
   import dct_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // harness
   // ------------------------------------------------------------
   logic clk, srst, hsel, hwrite, hready, hreadyout, hresp, term_en, read_allowed;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] bank_open;
   dct_pins_t pins;
   int num_errors = 0;
   int tests_run = 0;
   assign hready = hreadyout;
   dct_top dct_top_inst (.clk(clk), .srst(srst), .pins(pins), .term_en(term_en),
      .read_allowed(read_allowed), .bank_open(bank_open), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
   dct_ctrl_model ctl (.clk(clk), .pins(pins));
   // fixed clock; its rate never changes mid-run
   initial
   begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // single word transfer; waits on hready, no fixed latency assumed
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'h1) @(posedge clk);
      htrans <= 2'h0;
      hsel <= 1'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'h1) @(posedge clk);
      rd = hrdata;
      chk(32'(hresp), 32'h0);
   endtask
   task rdchk(input logic [31:0] a, input logic [31:0] exp);
      ahb(1'h0, a, 32'h0);
      chk(rd, exp);
   endtask
   // power-down round trip; counts cycles until reads open again
   task measure(input logic sref, output int n);
      ctl.power(1'h0, sref);
      repeat (6) @(posedge clk);
      ctl.power(1'h1, 1'h0);
      n = 0;
      // sample on the falling edge, where the state output has settled
      do
      begin
         @(negedge clk);
         n++;
      end
      while (read_allowed === 1'h1 && n < 20);
      while (read_allowed !== 1'h1) @(negedge clk) n++;
      repeat (SELFREFRESH_EXIT_READ_CYC) @(posedge clk);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_regs;
      rdchk(32'h0, 32'h1);
      rdchk(32'h4, 32'h0000_1002);
      ahb(1'h1, 32'h0, 32'h0);
      rdchk(32'h0, 32'h0);
      ahb(1'h1, 32'h0, 32'h1);
      rdchk(32'h0, 32'h1);
      ahb(1'h1, 32'h1C, 32'hFFFF_FFFF);
      rdchk(32'h1C, 32'h0);
      $display("register test done");
   endtask
   task t_term;
      int on, off;
      ctl.set_odt(1'h1);
      // count half clocks, sampled just after each edge, so the off path
      // shows its extra half clock; two synchroniser stages come first
      on = 0;
      while (term_en !== 1'h1 && on < 40)
      begin
         @(clk);
         #1;
         on++;
      end
      chk(32'(on), 32'(2 * (2 + TERM_ON_DELAY_CYC)));
      rdchk(32'h4, 32'h0000_1006);
      ctl.set_odt(1'h0);
      off = 0;
      while (term_en !== 1'h0 && off < 40)
      begin
         @(clk);
         #1;
         off++;
      end
      chk(32'(term_en), 32'h0);
      chk(32'(off), 32'(on + 1));
      $display("termination test done");
   endtask
   task t_autopre;
      int n [2];
      for (int i = 0; i < 2; i++)
      begin
         ctl.slack = i * 3;
         ctl.mode(2'h0, {2'h0, 3'(1 + 4 * i), 9'h0});
         rdchk(32'h8, 32'(1 + 4 * i));
         ctl.act(2'h1);
         ctl.wr_ap(2'h1);
         // start from the write command, so the model's slack cancels out
         n[i] = ctl.slack;
         while (bank_open[1] !== 1'h0) @(negedge clk) n[i]++;
      end
      ctl.slack = 0;
      chk(32'(n[1] - n[0]), 32'h4);
      $display("auto precharge test done");
   endtask
   task t_power;
      int f, s, p, r;
      ctl.mode(2'h0, 14'h0);
      ctl.act(2'h0);
      repeat (3) @(posedge clk);
      chk(32'(bank_open), 32'h1);
      measure(1'h0, f);
      ctl.pre_all();
      ctl.mode(2'h0, 14'h1000);
      ctl.mode(2'h1, 14'h0008);
      rdchk(32'h8, 32'h30);
      ctl.act(2'h0);
      measure(1'h0, s);
      chk(32'(s - f), 32'h3);
      ctl.pre_all();
      ctl.refresh();
      measure(1'h0, p);
      chk(32'(p - f), 32'h0);
      measure(1'h1, r);
      chk(32'(r - f), 32'(SELFREFRESH_EXIT_READ_CYC - ACTIVE_PD_FAST_EXIT_CYC));
      $display("power-down exit test done");
   endtask
   task end_of_test;
      $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // main sequence
   initial
   begin
      srst = 1'h1;
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (10) @(posedge clk);
      srst <= 1'h0;
      repeat (4) @(posedge clk);
      t_regs();
      t_term();
      t_autopre();
      t_power();
      end_of_test();
   end
   // watchdog; whole run needs about twelve hundred cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_of_test();
   end
endmodule // testbench
`default_nettype wire

//--- dct_top.sv
/*
 * dct_top: memory-side command tracking for a four-bank DDR2 device:
 * mode capture, bank state, auto-precharge write delay, power-down exit
 * read gating and termination on/off timing, with an AHB-Lite slave.
 * Assumes pins arrive asynchronously and the controller keeps its own
 * command spacing; this block only reports what it sees.
 */
// Our own choices: the address map and the AHB-Lite register port.
`default_nettype none
module dct_top
   import dct_pkg::*;
#(
   parameter int TIMER_W = 8
)
(
   input wire logic clk,
   input wire logic srst,
   input wire dct_pins_t pins,
   output logic term_en,
   output logic read_allowed,
   output logic [NUM_BANKS-1:0] bank_open,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);
   // ------------------------------------------------------------------
   // pin synchroniser: stage one feeds stage two only
   // ------------------------------------------------------------------
   // idle pin levels: deselected, clock enable high, no termination request,
   // so the termination path sees no false request right after reset
   localparam dct_pins_t PINS_IDLE = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1,
      cas_n: 1'b1, we_n: 1'b1, default: '0};
   dct_pins_t sync1_r;
   dct_pins_t sync2_r;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sync1_r <= PINS_IDLE;
         sync2_r <= PINS_IDLE;
      end
      else
      begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
      end
   end

   // ------------------------------------------------------------------
   // command decode on the synchronised pins
   // ------------------------------------------------------------------
   logic sel;
   logic cmd_mrs;
   logic cmd_ref;
   logic cmd_pre;
   logic cmd_act;
   logic cmd_wr;
   logic cmd_rd;
   logic cke_prev_r;
   logic cke_rise;
   logic cke_fall;
   assign sel = ~sync2_r.cs_n & cke_prev_r;
   assign cmd_mrs = sel & ~sync2_r.ras_n & ~sync2_r.cas_n & ~sync2_r.we_n;
   assign cmd_ref = sel & ~sync2_r.ras_n & ~sync2_r.cas_n & sync2_r.we_n;
   assign cmd_pre = sel & ~sync2_r.ras_n & sync2_r.cas_n & ~sync2_r.we_n;
   assign cmd_act = sel & ~sync2_r.ras_n & sync2_r.cas_n & sync2_r.we_n;
   assign cmd_wr = sel & sync2_r.ras_n & ~sync2_r.cas_n & ~sync2_r.we_n;
   assign cmd_rd = sel & sync2_r.ras_n & ~sync2_r.cas_n & sync2_r.we_n;
   assign cke_rise = sync2_r.cke & ~cke_prev_r;
   assign cke_fall = ~sync2_r.cke & cke_prev_r;

   // ------------------------------------------------------------------
   // mode capture: write recovery, exit speed, additive latency
   // ------------------------------------------------------------------
   logic [2:0] mr_wr_r;
   logic [2:0] mr_wr_nxt;
   logic mr_slow_r;
   logic mr_slow_nxt;
   logic [2:0] emr_al_r;
   logic [2:0] emr_al_nxt;
   always_comb
   begin
      mr_wr_nxt = mr_wr_r;
      mr_slow_nxt = mr_slow_r;
      emr_al_nxt = emr_al_r;
      if (cmd_mrs && sync2_r.ba == 2'h0)
      begin
         mr_wr_nxt = sync2_r.addr[MR_WR_LSB +: 3];
         mr_slow_nxt = sync2_r.addr[MR_SLOW_EXIT_BIT];
      end
      if (cmd_mrs && sync2_r.ba == 2'h1)
      begin
         emr_al_nxt = sync2_r.addr[EMR_AL_LSB +: 3];
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         mr_wr_r <= 3'h0;
         mr_slow_r <= 1'b0;
         emr_al_r <= 3'h0;
         cke_prev_r <= 1'b1;
      end
      else
      begin
         mr_wr_r <= mr_wr_nxt;
         mr_slow_r <= mr_slow_nxt;
         emr_al_r <= emr_al_nxt;
         cke_prev_r <= sync2_r.cke;
      end
   end

   // ------------------------------------------------------------------
   // bank state; write with auto-precharge closes after the write delay
   // ------------------------------------------------------------------
   logic [TIMER_W-1:0] autoprecharge_write_delay_cyc;
   logic [NUM_BANKS-1:0] open_r;
   logic [NUM_BANKS-1:0] open_nxt;
   logic [NUM_BANKS-1:0] tmr_load;
   logic [NUM_BANKS-1:0] tmr_busy;
   logic [NUM_BANKS-1:0] tmr_done;
   // write recovery field holds count minus one
   assign autoprecharge_write_delay_cyc = TIMER_W'(mr_wr_r) + TIMER_W'(1) + TIMER_W'(PRECHARGE_PERIOD_CYC);

   genvar gb;
   generate
      for (gb = 0; gb < NUM_BANKS; gb++)
      begin : g_bank
         logic hit;
         assign hit = (sync2_r.ba == 2'(gb));
         assign tmr_load[gb] = cmd_wr & hit & sync2_r.addr[PRECHARGE_ALL_BIT];
         always_comb
         begin
            open_nxt[gb] = open_r[gb];
            if (cmd_act && hit)
            begin
               open_nxt[gb] = 1'b1;
            end
            if (cmd_pre && (hit || sync2_r.addr[PRECHARGE_ALL_BIT]))
            begin
               open_nxt[gb] = 1'b0;
            end
            if (cmd_rd && hit && sync2_r.addr[PRECHARGE_ALL_BIT])
            begin
               open_nxt[gb] = 1'b0;
            end
            if (tmr_done[gb])
            begin
               open_nxt[gb] = 1'b0;
            end
         end
         dct_bank_timer #(.W(TIMER_W)) u_tmr (
            .clk(clk),
            .srst(srst),
            .load(tmr_load[gb]),
            .load_val(autoprecharge_write_delay_cyc),
            .busy(tmr_busy[gb]),
            .done(tmr_done[gb])
         );
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         open_r <= '0;
      end
      else
      begin
         open_r <= open_nxt;
      end
   end
   assign bank_open = open_r;

   // ------------------------------------------------------------------
   // power state and read gating after an exit
   // ------------------------------------------------------------------
   dct_pstate_t ps_r;
   dct_pstate_t ps_nxt;
   logic [7:0] exit_cnt_r;
   logic [7:0] exit_cnt_nxt;
   logic [7:0] slow_gap;
   // slow exit gap shrinks with additive latency, floored at one clock
   assign slow_gap = (emr_al_r >= 3'(ACTIVE_PD_SLOW_EXIT_BASE_CYC)) ? 8'h01 :
      8'(ACTIVE_PD_SLOW_EXIT_BASE_CYC) - 8'(emr_al_r);
   always_comb
   begin
      ps_nxt = ps_r;
      exit_cnt_nxt = exit_cnt_r;
      unique case (ps_r)
         PS_ACTIVE:
         begin
            if (cke_fall)
            begin
               if (cmd_ref || (~sync2_r.cs_n & ~sync2_r.ras_n & ~sync2_r.cas_n & sync2_r.we_n))
               begin
                  ps_nxt = PS_SELFREF;
               end
               else if (open_r != '0)
               begin
                  ps_nxt = PS_PD_ACT;
               end
               else
               begin
                  ps_nxt = PS_PD_PRE;
               end
            end
         end
         PS_PD_PRE:
         begin
            if (cke_rise)
            begin
               ps_nxt = PS_EXIT;
               exit_cnt_nxt = 8'(PRECHARGE_PD_EXIT_CYC);
            end
         end
         PS_PD_ACT:
         begin
            if (cke_rise)
            begin
               ps_nxt = PS_EXIT;
               exit_cnt_nxt = mr_slow_r ? slow_gap : 8'(ACTIVE_PD_FAST_EXIT_CYC);
            end
         end
         PS_SELFREF:
         begin
            if (cke_rise)
            begin
               ps_nxt = PS_EXIT;
               exit_cnt_nxt = 8'(SELFREFRESH_EXIT_READ_CYC);
            end
         end
         PS_EXIT:
         begin
            if (exit_cnt_r <= 8'h01)
            begin
               exit_cnt_nxt = 8'h00;
               ps_nxt = PS_ACTIVE;
            end
            else
            begin
               exit_cnt_nxt = exit_cnt_r - 8'h01;
            end
         end
         default:
         begin
            ps_nxt = PS_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ps_r <= PS_ACTIVE;
         exit_cnt_r <= 8'h00;
      end
      else
      begin
         ps_r <= ps_nxt;
         exit_cnt_r <= exit_cnt_nxt;
      end
   end
   assign read_allowed = (ps_r == PS_ACTIVE);

   // ------------------------------------------------------------------
   // termination timing: on at two edges, off half a clock later
   // ------------------------------------------------------------------
   // the falling-edge copy stretches only the off edge by half a clock
   logic [TERM_ON_DELAY_CYC-1:0] odt_pipe_r;
   logic [TERM_ON_DELAY_CYC-1:0] odt_pipe_nxt;
   logic odt_half_r;
   logic [31:0] ctrl_r;
   logic [31:0] ctrl_nxt;
   logic term_ctrl_en;
   logic active_op;
   assign active_op = (ps_r == PS_ACTIVE) || (ps_r == PS_EXIT);
   assign term_ctrl_en = ctrl_r[CTRL_TERM_EN_BIT];
   always_comb
   begin
      odt_pipe_nxt = {odt_pipe_r[TERM_ON_DELAY_CYC-2:0], sync2_r.odt & term_ctrl_en};
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         odt_pipe_r <= '0;
      end
      else
      begin
         odt_pipe_r <= odt_pipe_nxt;
      end
   end

   always_ff @(negedge clk)
   begin
      if (srst)
      begin
         odt_half_r <= 1'b0;
      end
      else
      begin
         odt_half_r <= odt_pipe_r[TERM_ON_DELAY_CYC-1];
      end
   end
   // in power-down the timing is loose, so follow the control directly
   assign term_en = active_op ? (odt_pipe_r[TERM_ON_DELAY_CYC-1] | odt_half_r) :
      (sync2_r.odt & term_ctrl_en);

   // ------------------------------------------------------------------
   // AHB-Lite slave: zero wait, read data prepared in the address phase
   // ------------------------------------------------------------------
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic wr_pend_r;
   logic wr_pend_nxt;
   logic [7:0] wr_addr_r;
   logic [7:0] wr_addr_nxt;
   logic take;
   assign take = hsel & hready & htrans[1];
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      rdata_nxt = rdata_r;
      wr_pend_nxt = take & hwrite;
      wr_addr_nxt = take ? haddr[7:0] : wr_addr_r;
      if (wr_pend_r && wr_addr_r == REG_CTRL_OFS)
      begin
         ctrl_nxt = {31'h0000_0000, hwdata[CTRL_TERM_EN_BIT]};
      end
      if (take && !hwrite)
      begin
         unique case (haddr[7:0])
            REG_CTRL_OFS: rdata_nxt = ctrl_nxt;
            REG_STATUS_OFS: rdata_nxt = {15'h0000, ps_r, tmr_busy, open_r,
               1'b0, term_en, read_allowed, 1'b0};
            REG_MODE_OFS: rdata_nxt = {24'h00_0000, emr_al_r, mr_slow_r, 1'b0, mr_wr_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl_r <= CTRL_RESET;
         rdata_r <= 32'h0000_0000;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         rdata_r <= rdata_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_r;
endmodule // dct_top
`default_nettype wire
